//--- dv/port_pin_function_select_tb_top.sv
// Bench for the port pin function select block
`include "ppfs_cfg.svh"
module port_pin_function_select_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 1'h0;
	logic sys_rst_i = 1'h1;
	logic [31:0] s_axi_awaddr_i = 32'h0, s_axi_wdata_i = 32'h0, s_axi_araddr_i = 32'h0;
	logic [31:0] s_axi_rdata_o;
	logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
	logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, s_axi_awready_o, s_axi_wready_o;
	logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, adc_trigger_in_o, ser3_clk_in_o;
	logic wait_req_o, dma_ack_2_a_i, dma_done_2_i, dma_ack_3_i, dma_done_3_i, dma_done_0_i;
	logic dma_done_1_i, ser3_clk_out_i, ser3_clk_oe_i, ser3_tx_i, sdram_clk_en_out_i;
	logic dram_succ_read_i, sdram_write_strobe_i, area_addr_strobe_i, dram_succ_write_i;
	logic area45_select_i, bus_release_monitor_i;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o, p1_pin_o, p1_pin_oe_o, timer_event_in_o;
	logic [1:0] p3_pin_o, p3_pin_oe_o, p1_pin_i, p1_gpio_out_i, p1_gpio_oe_i, p3_pin_i;
	logic [1:0] p3_gpio_out_i, p3_gpio_oe_i;
	logic [2:0] dma_request_o;
	logic [3:0] s_axi_wstrb_i = 4'hF;
	logic [3:0] ser0_out_i, ser0_oe_i, fser0_out_i, fser0_oe_i, ser1_out_i, ser1_oe_i;
	logic [3:0] ser2_out_i, ser2_oe_i, ser0_in_o, fifo_serial_rx_o, ser1_in_o, ser2_in_o;
	logic [4:0] k5_pin_i, k6_pin_i, k5_port_o, k6_port_o, adc_ch_en_o;
	logic [5:0] timer16_out_i;
	logic [7:0] p0_pin_i, p0_gpio_out_i, p0_gpio_oe_i, p2_pin_i, p2_gpio_out_i, p2_gpio_oe_i;
	logic [7:0] p0_pin_o, p0_pin_oe_o, p0_port_sel_o, p2_pin_o, p2_pin_oe_o;
	logic [123:0] far;
	ppfs_pkg::ppfs_route_s route_o;
	int mismatches = 0;
	int checks = 0;
	int cyc = 0;
	logic [31:0] regs [15] = '{`PPFS_OFS_K5, `PPFS_OFS_K6, `PPFS_OFS_P0, `PPFS_OFS_P1,
		`PPFS_OFS_P1IO, `PPFS_OFS_S3, `PPFS_OFS_P2, `PPFS_OFS_S2, `PPFS_OFS_P3, `PPFS_OFS_P3IO,
		`PPFS_OFS_EX, `PPFS_OFS_P0EF, `PPFS_OFS_P2EF, `PPFS_OFS_P3EF, `PPFS_OFS_PAEF};
	assign {k5_pin_i, k6_pin_i, p0_pin_i, p0_gpio_out_i, p0_gpio_oe_i, ser0_out_i, ser0_oe_i,
		fser0_out_i, fser0_oe_i, ser1_out_i, ser1_oe_i, dma_ack_2_a_i, dma_done_2_i, dma_ack_3_i,
		dma_done_3_i, p1_pin_i, p1_gpio_out_i, p1_gpio_oe_i, dma_done_0_i, dma_done_1_i,
		ser3_clk_out_i, ser3_clk_oe_i, ser3_tx_i, p2_pin_i, p2_gpio_out_i, p2_gpio_oe_i,
		sdram_clk_en_out_i, dram_succ_read_i, sdram_write_strobe_i, area_addr_strobe_i,
		dram_succ_write_i, timer16_out_i, ser2_out_i, ser2_oe_i, p3_pin_i, p3_gpio_out_i,
		p3_gpio_oe_i, area45_select_i, bus_release_monitor_i} = far;
	ppfs_top u_ppfs_top (.*);
	ppfs_far_model u_ppfs_far_model (.mclk_i(mclk_i), .far_o(far));
	always #10 mclk_i = ~mclk_i;
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test
	// Hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			stop_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// One access; readies sampled at the falling edge, so each release lands on its taking edge
	task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] d,
		input logic [1:0] er);
		logic aw, wd, ar, done;
		logic [31:0] rd;
		logic [1:0] rs;
		@(posedge mclk_i);
		s_axi_awaddr_i <= a;
		s_axi_araddr_i <= a;
		s_axi_wdata_i <= {24'h000000, d};
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= {3{w}};
		{s_axi_arvalid_i, s_axi_rready_i} <= {2{~w}};
		do begin
			@(negedge mclk_i);
			aw = s_axi_awready_o;
			wd = s_axi_wready_o;
			ar = s_axi_arready_o;
			done = w ? s_axi_bvalid_o : s_axi_rvalid_o;
			rs = w ? s_axi_bresp_o : s_axi_rresp_o;
			rd = s_axi_rdata_o;
			@(posedge mclk_i);
			if (aw) s_axi_awvalid_i <= 1'h0;
			if (wd) s_axi_wvalid_i <= 1'h0;
			if (ar) s_axi_arvalid_i <= 1'h0;
		end while (!done);
		{s_axi_bready_i, s_axi_rready_i} <= 2'h0;
		chk("resp", rs, er);
		if (!w) chk("rdata", rd, {24'h000000, d});
	endtask : acc
	initial begin
		repeat (4) @(posedge mclk_i);
		sys_rst_i <= 1'h0;
		foreach (regs[i]) acc(1'h0, regs[i], 8'h00, 2'h0);
		acc(1'h0, 32'h000402C1, 8'h00, 2'h2);
		@(negedge mclk_i);
		chk("p0 owner", p0_port_sel_o, 8'hFF);
		chk("k5 port", k5_port_o, k5_pin_i);
		$display("end reset");
		acc(1'h1, `PPFS_OFS_K5, 8'h0F, 2'h0);
		acc(1'h1, `PPFS_OFS_K6, 8'h1F, 2'h0);
		@(negedge mclk_i);
		chk("dma req", dma_request_o, {k5_pin_i[3], k5_pin_i[1], k5_pin_i[0]});
		chk("adc trig", adc_trigger_in_o, k5_pin_i[2]);
		chk("adc ch", adc_ch_en_o, 5'h1F);
		chk("k5 port", k5_port_o, {k5_pin_i[4], 4'h0});
		acc(1'h0, `PPFS_OFS_K5, 8'h0F, 2'h0);
		s_axi_wstrb_i <= 4'hE;
		acc(1'h1, `PPFS_OFS_K6, 8'h00, 2'h0);
		acc(1'h0, `PPFS_OFS_K6, 8'h1F, 2'h0);
		s_axi_wstrb_i <= 4'hF;
		$display("end k ports");
		acc(1'h1, `PPFS_OFS_P0, 8'hFF, 2'h0);
		acc(1'h1, `PPFS_OFS_EX, 8'hF0, 2'h0);
		@(negedge mclk_i);
		chk("ser0 in", ser0_in_o, p0_pin_i[3:0]);
		chk("dma pins", p0_pin_o[7:4], {dma_done_3_i, dma_ack_3_i, dma_done_2_i, dma_ack_2_a_i});
		chk("dma oe", p0_pin_oe_o[7:4], 4'hF);
		acc(1'h1, `PPFS_OFS_P0EF, 8'h55, 2'h0);
		acc(1'h1, `PPFS_OFS_EX, 8'h00, 2'h0);
		@(negedge mclk_i);
		chk("fifo in", fifo_serial_rx_o, p0_pin_i[3:0]);
		chk("ser0 idle", ser0_in_o, 4'hF);
		chk("ser1 in", ser1_in_o, p0_pin_i[7:4]);
		$display("end p0");
		acc(1'h1, `PPFS_OFS_P1, 8'h60, 2'h0);
		@(negedge mclk_i);
		chk("tmr evt", timer_event_in_o, p1_pin_i);
		acc(1'h1, `PPFS_OFS_P1IO, 8'h60, 2'h0);
		@(negedge mclk_i);
		chk("dma end", p1_pin_o, {dma_done_1_i, dma_done_0_i});
		acc(1'h1, `PPFS_OFS_P1, 8'h00, 2'h0);
		acc(1'h1, `PPFS_OFS_S3, 8'h06, 2'h0);
		@(negedge mclk_i);
		chk("ser3", {p1_pin_o[1], ser3_clk_in_o}, {ser3_tx_i, p1_pin_i[0]});
		acc(1'h1, `PPFS_OFS_P2EF, 8'h05, 2'h0);
		acc(1'h1, `PPFS_OFS_P2, 8'hFC, 2'h0);
		@(negedge mclk_i);
		chk("p2 out", p2_pin_o[7:2], timer16_out_i);
		chk("sd cke", p2_pin_o[0], sdram_clk_en_out_i);
		chk("sd we", p2_pin_o[1], sdram_write_strobe_i);
		acc(1'h1, `PPFS_OFS_P2, 8'h00, 2'h0);
		acc(1'h1, `PPFS_OFS_S2, 8'h0F, 2'h0);
		@(negedge mclk_i);
		chk("ser2 in", ser2_in_o, {p2_pin_i[4], p2_pin_i[5], p2_pin_i[6], p2_pin_i[7]});
		acc(1'h1, `PPFS_OFS_P3, 8'h03, 2'h0);
		@(negedge mclk_i);
		chk("wait", wait_req_o, p3_pin_i[0]);
		chk("bus mon", p3_pin_o[1], bus_release_monitor_i);
		acc(1'h1, `PPFS_OFS_PAEF, 8'h10, 2'h0);
		@(negedge mclk_i);
		chk("wait off", wait_req_o, 1'h1);
		acc(1'h1, `PPFS_OFS_PAEF, 8'h00, 2'h0);
		acc(1'h1, `PPFS_OFS_P3IO, 8'h01, 2'h0);
		acc(1'h1, `PPFS_OFS_EX, 8'h08, 2'h0);
		@(negedge mclk_i);
		chk("ce45", p3_pin_o[0], area45_select_i);
		chk("mon off", p3_pin_o[1], p3_gpio_out_i[1]);
		$display("end p1 p2 p3");
		stop_test();
	end
endmodule : port_pin_function_select_tb_top

//--- dv/ppfs_far_model.sv
// Far-side stand-in: pin levels and peripheral drives as one moving pattern
module ppfs_far_model (
	input wire logic mclk_i, // System clock
	output logic [123:0] far_o // Pin levels and peripheral drives
);
	timeunit 1ns;
	timeprecision 1ns;
	initial far_o = {31{4'h9}};
	// Changes every cycle, so a stale or wrong route cannot match by luck
	always @(posedge mclk_i) begin
		far_o <= {far_o[122:0], ~(far_o[123] ^ far_o[86])};
	end
endmodule : ppfs_far_model

//--- hdl/ppfs_cfg.svh
// Constants for the port pin function select block
//------------------------------------------------------------
// Function
//------------------------------------------------------------
// Function
// - K50 input port or DMA request 0
// - K51/K53 input port or DMA requests 1/2
// - K52 input port or A/D trigger
// - K60-K64 input port or A/D channels
// - P00-P03 field 01 selects FIFO serial 0
// - P00-P03 serial 0 when field 00 and bit
// - P04-P07 extended bits give DMA ack/end
// - P04-P07 serial 1 when extended bits clear
// - P15/P16 timer input or DMA end output
// - P15/P16 serial 3 clock/data when bit clear
// - P20 SDRAM clock enable or DRAM read
// - P21 SDRAM write, area strobe, DRAM write
// - P22-P27 timer outputs when bits set
// - P24-P27 serial 2 when timer bit clear
// - P30 port, wait input or area45 select
// - P31 bus release monitor output
// - All select bits reset to zero
`ifndef PPFS_CFG_SVH
`define PPFS_CFG_SVH
`define PPFS_OFS_K5 32'h000402C0
`define PPFS_OFS_K6 32'h000402C3
`define PPFS_OFS_P0 32'h000402D0
`define PPFS_OFS_P1 32'h000402D4
`define PPFS_OFS_P1IO 32'h000402D6
`define PPFS_OFS_S3 32'h000402D7
`define PPFS_OFS_P2 32'h000402D8
`define PPFS_OFS_S2 32'h000402DB
`define PPFS_OFS_P3 32'h000402DC
`define PPFS_OFS_P3IO 32'h000402DE
`define PPFS_OFS_EX 32'h000402DF
`define PPFS_OFS_P0EF 32'h00300040
`define PPFS_OFS_P2EF 32'h00300044
`define PPFS_OFS_P3EF 32'h00300046
`define PPFS_OFS_PAEF 32'h00300F60
`define PPFS_REG_RST 8'h00
`define PPFS_FLD_GPIO 2'h0
`define PPFS_FLD_ALT 2'h1
`define PPFS_RESP_OK 2'h0
`define PPFS_RESP_ERR 2'h2
`endif

//--- hdl/ppfs_pkg.sv
// Types for the port pin function select block
package ppfs_pkg;
	typedef enum logic [3:0] {
		REG_K5, REG_K6, REG_P0, REG_P1, REG_P1IO, REG_S3, REG_P2, REG_S2,
		REG_P3, REG_P3IO, REG_EX, REG_P0EF, REG_P2EF, REG_P3EF, REG_PAEF, REG_NONE
	} ppfs_reg_e;
	// Per-pin routing: port owns the pin, peripheral owns it
	typedef struct packed {
		logic [4:0] k5_alt;
		logic [4:0] k6_alt;
		logic [7:0] p0_port;
		logic [7:0] p1_port;
		logic [7:0] p2_port;
		logic [1:0] p3_port;
	} ppfs_route_s;
endpackage : ppfs_pkg

//--- hdl/ppfs_top.sv
// Port pin function multiplexer with AXI4-Lite register slave
//
// Implementation choice: the AXI4-Lite register port.
`include "ppfs_cfg.svh"
module ppfs_top (
	input wire logic mclk_i, // System clock
	input wire logic sys_rst_i, // Synchronous reset, active high
	input wire logic [31:0] s_axi_awaddr_i, // Write address
	input wire logic s_axi_awvalid_i, // Write address valid
	output logic s_axi_awready_o, // Write address ready
	input wire logic [31:0] s_axi_wdata_i, // Write data
	input wire logic [3:0] s_axi_wstrb_i, // Write strobes
	input wire logic s_axi_wvalid_i, // Write data valid
	output logic s_axi_wready_o, // Write data ready
	output logic [1:0] s_axi_bresp_o, // Write response
	output logic s_axi_bvalid_o, // Write response valid
	input wire logic s_axi_bready_i, // Write response ready
	input wire logic [31:0] s_axi_araddr_i, // Read address
	input wire logic s_axi_arvalid_i, // Read address valid
	output logic s_axi_arready_o, // Read address ready
	output logic [31:0] s_axi_rdata_o, // Read data
	output logic [1:0] s_axi_rresp_o, // Read response
	output logic s_axi_rvalid_o, // Read valid
	input wire logic s_axi_rready_i, // Read ready
	input wire logic [4:0] k5_pin_i, // K50-K54 pin levels
	input wire logic [4:0] k6_pin_i, // K60-K64 pin levels
	output logic [4:0] k5_port_o, // K5 port data, 0 when pin is taken
	output logic [4:0] k6_port_o, // K6 port data, 0 when pin is taken
	output logic [2:0] dma_request_o, // DMA request 0..2 (pin level)
	output logic adc_trigger_in_o, // A/D trigger (pin level)
	output logic [4:0] adc_ch_en_o, // A/D channel pin connected
	input wire logic [7:0] p0_pin_i, // P00-P07 pin levels
	input wire logic [7:0] p0_gpio_out_i, // P0 port output data
	input wire logic [7:0] p0_gpio_oe_i, // P0 port output enable
	output logic [7:0] p0_pin_o, // P0 pin drive
	output logic [7:0] p0_pin_oe_o, // P0 pin enable
	output logic [7:0] p0_port_sel_o, // P0 owned by port
	input wire logic [3:0] ser0_out_i, // Serial 0 out/oe: tx,clk,rdy as out
	input wire logic [3:0] ser0_oe_i, // Serial 0 per-pin enables
	input wire logic [3:0] fser0_out_i, // FIFO serial 0 pin drives
	input wire logic [3:0] fser0_oe_i, // FIFO serial 0 pin enables
	input wire logic [3:0] ser1_out_i, // Serial 1 pin drives
	input wire logic [3:0] ser1_oe_i, // Serial 1 pin enables
	output logic [3:0] ser0_in_o, // Serial 0 pin inputs
	output logic [3:0] fifo_serial_rx_o, // FIFO serial 0 pin inputs
	output logic [3:0] ser1_in_o, // Serial 1 pin inputs
	input wire logic dma_ack_2_a_i, // DMA ch2 acknowledge
	input wire logic dma_done_2_i, // DMA ch2 end
	input wire logic dma_ack_3_i, // DMA ch3 acknowledge
	input wire logic dma_done_3_i, // DMA ch3 end
	input wire logic [1:0] p1_pin_i, // P15,P16 pin levels
	input wire logic [1:0] p1_gpio_out_i, // P15,P16 port data
	input wire logic [1:0] p1_gpio_oe_i, // P15,P16 port enable
	output logic [1:0] p1_pin_o, // P15,P16 drive
	output logic [1:0] p1_pin_oe_o, // P15,P16 enable
	output logic [1:0] timer_event_in_o, // Timer 4/5 event inputs
	input wire logic dma_done_0_i, // DMA end for P15
	input wire logic dma_done_1_i, // DMA end for P16
	input wire logic ser3_clk_out_i, // Serial 3 clock drive
	input wire logic ser3_clk_oe_i, // Serial 3 clock enable
	output logic ser3_clk_in_o, // Serial 3 clock input
	input wire logic ser3_tx_i, // Serial 3 data out
	input wire logic [7:0] p2_pin_i, // P20-P27 pin levels
	input wire logic [7:0] p2_gpio_out_i, // P2 port data
	input wire logic [7:0] p2_gpio_oe_i, // P2 port enable
	output logic [7:0] p2_pin_o, // P2 drive
	output logic [7:0] p2_pin_oe_o, // P2 enable
	input wire logic sdram_clk_en_out_i, // SDRAM clock enable
	input wire logic dram_succ_read_i, // DRAM successive read
	input wire logic sdram_write_strobe_i, // SDRAM write strobe
	input wire logic area_addr_strobe_i, // Area address strobe
	input wire logic dram_succ_write_i, // DRAM successive write
	input wire logic [5:0] timer16_out_i, // Timer 0..5 outputs
	input wire logic [3:0] ser2_out_i, // Serial 2 rdy,clk,tx,rx drives
	input wire logic [3:0] ser2_oe_i, // Serial 2 enables
	output logic [3:0] ser2_in_o, // Serial 2 rdy,clk,tx,rx inputs
	input wire logic [1:0] p3_pin_i, // P30,P31 pin levels
	input wire logic [1:0] p3_gpio_out_i, // P30,P31 port data
	input wire logic [1:0] p3_gpio_oe_i, // P30,P31 port enable
	output logic [1:0] p3_pin_o, // P30,P31 drive
	output logic [1:0] p3_pin_oe_o, // P30,P31 enable
	output logic wait_req_o, // Wait request (pin level)
	input wire logic area45_select_i, // Area 4/5 chip enable
	input wire logic bus_release_monitor_i, // Bus release monitor
	output ppfs_pkg::ppfs_route_s route_o // Port ownership summary
);
	//------------------------------------------------------------
	// Register file
	//------------------------------------------------------------
	logic [7:0] k5_function_select_r, k6_function_select_r, p0_function_select_r;
	logic [7:0] p1_function_select_r, p1_io_control_r, serial3_pin_select_r;
	logic [7:0] p2_function_select_r, serial2_pin_select_r, p3_function_select_r;
	logic [7:0] p3_io_control_r, port_extended_function_r, p0_ext_select_fields_r;
	logic [7:0] p2_ext_select_fields_r, p3_ext_select_fields_r, pa_select_fields_r;
	logic aw_full_r, w_full_r;
	logic [31:0] awaddr_r;
	logic [7:0] wbyte_r;
	logic wlane_r;

	function automatic ppfs_pkg::ppfs_reg_e decode(input logic [31:0] a);
		unique case (a)
			`PPFS_OFS_K5: decode = ppfs_pkg::REG_K5;
			`PPFS_OFS_K6: decode = ppfs_pkg::REG_K6;
			`PPFS_OFS_P0: decode = ppfs_pkg::REG_P0;
			`PPFS_OFS_P1: decode = ppfs_pkg::REG_P1;
			`PPFS_OFS_P1IO: decode = ppfs_pkg::REG_P1IO;
			`PPFS_OFS_S3: decode = ppfs_pkg::REG_S3;
			`PPFS_OFS_P2: decode = ppfs_pkg::REG_P2;
			`PPFS_OFS_S2: decode = ppfs_pkg::REG_S2;
			`PPFS_OFS_P3: decode = ppfs_pkg::REG_P3;
			`PPFS_OFS_P3IO: decode = ppfs_pkg::REG_P3IO;
			`PPFS_OFS_EX: decode = ppfs_pkg::REG_EX;
			`PPFS_OFS_P0EF: decode = ppfs_pkg::REG_P0EF;
			`PPFS_OFS_P2EF: decode = ppfs_pkg::REG_P2EF;
			`PPFS_OFS_P3EF: decode = ppfs_pkg::REG_P3EF;
			`PPFS_OFS_PAEF: decode = ppfs_pkg::REG_PAEF;
			default: decode = ppfs_pkg::REG_NONE;
		endcase
	endfunction : decode

	// Offsets are byte addresses not all word aligned; the whole byte
	// address is decoded and the 8-bit value sits in lane 0.
	logic do_write;
	ppfs_pkg::ppfs_reg_e wsel;
	assign do_write = aw_full_r && w_full_r && !s_axi_bvalid_o;
	assign wsel = decode(awaddr_r);
	assign s_axi_awready_o = !aw_full_r && !s_axi_bvalid_o;
	assign s_axi_wready_o = !w_full_r && !s_axi_bvalid_o;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			aw_full_r <= 1'b0;
			awaddr_r <= 32'h00000000;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_full_r <= 1'b1;
			awaddr_r <= s_axi_awaddr_i;
		end else if (do_write) begin
			aw_full_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			w_full_r <= 1'b0;
			wbyte_r <= 8'h00;
			wlane_r <= 1'b0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_full_r <= 1'b1;
			wbyte_r <= s_axi_wdata_i[7:0];
			wlane_r <= s_axi_wstrb_i[0];
		end else if (do_write) begin
			w_full_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `PPFS_RESP_OK;
		end else if (do_write) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o <= (wsel == ppfs_pkg::REG_NONE) ? `PPFS_RESP_ERR : `PPFS_RESP_OK;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			k5_function_select_r <= `PPFS_REG_RST;
			k6_function_select_r <= `PPFS_REG_RST;
			p0_function_select_r <= `PPFS_REG_RST;
			p1_function_select_r <= `PPFS_REG_RST;
			p1_io_control_r <= `PPFS_REG_RST;
			serial3_pin_select_r <= `PPFS_REG_RST;
			p2_function_select_r <= `PPFS_REG_RST;
			serial2_pin_select_r <= `PPFS_REG_RST;
			p3_function_select_r <= `PPFS_REG_RST;
			p3_io_control_r <= `PPFS_REG_RST;
			port_extended_function_r <= `PPFS_REG_RST;
			p0_ext_select_fields_r <= `PPFS_REG_RST;
			p2_ext_select_fields_r <= `PPFS_REG_RST;
			p3_ext_select_fields_r <= `PPFS_REG_RST;
			pa_select_fields_r <= `PPFS_REG_RST;
		end else if (do_write && wlane_r) begin
			unique case (wsel)
				ppfs_pkg::REG_K5: k5_function_select_r <= wbyte_r;
				ppfs_pkg::REG_K6: k6_function_select_r <= wbyte_r;
				ppfs_pkg::REG_P0: p0_function_select_r <= wbyte_r;
				ppfs_pkg::REG_P1: p1_function_select_r <= wbyte_r;
				ppfs_pkg::REG_P1IO: p1_io_control_r <= wbyte_r;
				ppfs_pkg::REG_S3: serial3_pin_select_r <= wbyte_r;
				ppfs_pkg::REG_P2: p2_function_select_r <= wbyte_r;
				ppfs_pkg::REG_S2: serial2_pin_select_r <= wbyte_r;
				ppfs_pkg::REG_P3: p3_function_select_r <= wbyte_r;
				ppfs_pkg::REG_P3IO: p3_io_control_r <= wbyte_r;
				ppfs_pkg::REG_EX: port_extended_function_r <= wbyte_r;
				ppfs_pkg::REG_P0EF: p0_ext_select_fields_r <= wbyte_r;
				ppfs_pkg::REG_P2EF: p2_ext_select_fields_r <= wbyte_r;
				ppfs_pkg::REG_P3EF: p3_ext_select_fields_r <= wbyte_r;
				ppfs_pkg::REG_PAEF: pa_select_fields_r <= wbyte_r;
				ppfs_pkg::REG_NONE: ;
			endcase
		end
	end

	// Read channel: one cycle to answer, data held until rready
	logic [7:0] rbyte;
	ppfs_pkg::ppfs_reg_e rsel;
	assign rsel = decode(s_axi_araddr_i);
	assign s_axi_arready_o = !s_axi_rvalid_o;
	always_comb begin
		unique case (rsel)
			ppfs_pkg::REG_K5: rbyte = k5_function_select_r;
			ppfs_pkg::REG_K6: rbyte = k6_function_select_r;
			ppfs_pkg::REG_P0: rbyte = p0_function_select_r;
			ppfs_pkg::REG_P1: rbyte = p1_function_select_r;
			ppfs_pkg::REG_P1IO: rbyte = p1_io_control_r;
			ppfs_pkg::REG_S3: rbyte = serial3_pin_select_r;
			ppfs_pkg::REG_P2: rbyte = p2_function_select_r;
			ppfs_pkg::REG_S2: rbyte = serial2_pin_select_r;
			ppfs_pkg::REG_P3: rbyte = p3_function_select_r;
			ppfs_pkg::REG_P3IO: rbyte = p3_io_control_r;
			ppfs_pkg::REG_EX: rbyte = port_extended_function_r;
			ppfs_pkg::REG_P0EF: rbyte = p0_ext_select_fields_r;
			ppfs_pkg::REG_P2EF: rbyte = p2_ext_select_fields_r;
			ppfs_pkg::REG_P3EF: rbyte = p3_ext_select_fields_r;
			ppfs_pkg::REG_PAEF: rbyte = pa_select_fields_r;
			ppfs_pkg::REG_NONE: rbyte = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h00000000;
			s_axi_rresp_o <= `PPFS_RESP_OK;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= {24'h000000, rbyte};
			s_axi_rresp_o <= (rsel == ppfs_pkg::REG_NONE) ? `PPFS_RESP_ERR : `PPFS_RESP_OK;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// Pin multiplexer, purely combinational from the stored bits
	//------------------------------------------------------------
	logic [3:0] p0_fifo, p0_ser, p1h_dma, p1h_ser;
	logic [1:0] p1_alt, p1_s3;
	logic [5:0] p2_tm;
	logic [3:0] p2_s2;
	logic p20_sd, p20_dr, p21_sd, p21_ga, p21_dw, p30_alt, p31_mon;

	assign k5_port_o = k5_pin_i & ~k5_function_select_r[4:0];
	assign k6_port_o = k6_pin_i & ~k6_function_select_r[4:0];
	assign dma_request_o[0] = k5_function_select_r[0] ? k5_pin_i[0] : 1'b1;
	assign dma_request_o[1] = k5_function_select_r[1] ? k5_pin_i[1] : 1'b1;
	assign dma_request_o[2] = k5_function_select_r[3] ? k5_pin_i[3] : 1'b1;
	assign adc_trigger_in_o = k5_function_select_r[2] ? k5_pin_i[2] : 1'b1;
	assign adc_ch_en_o = k6_function_select_r[4:0];

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_p0
			assign p0_fifo[gi] = p0_ext_select_fields_r[2*gi+:2] == `PPFS_FLD_ALT;
			assign p0_ser[gi] = (p0_ext_select_fields_r[2*gi+:2] == `PPFS_FLD_GPIO)
				&& p0_function_select_r[gi];
			assign p1h_dma[gi] = port_extended_function_r[gi+4];
			assign p1h_ser[gi] = !port_extended_function_r[gi+4]
				&& p0_function_select_r[gi+4];
			assign fifo_serial_rx_o[gi] = p0_fifo[gi] ? p0_pin_i[gi] : 1'b1;
			assign ser0_in_o[gi] = p0_ser[gi] ? p0_pin_i[gi] : 1'b1;
			assign ser1_in_o[gi] = p1h_ser[gi] ? p0_pin_i[gi+4] : 1'b1;
			assign p0_pin_o[gi] = p0_fifo[gi] ? fser0_out_i[gi]
				: p0_ser[gi] ? ser0_out_i[gi] : p0_gpio_out_i[gi];
			assign p0_pin_oe_o[gi] = p0_fifo[gi] ? fser0_oe_i[gi]
				: p0_ser[gi] ? ser0_oe_i[gi] : p0_gpio_oe_i[gi];
			assign p0_pin_oe_o[gi+4] = p1h_dma[gi] ? 1'b1
				: p1h_ser[gi] ? ser1_oe_i[gi] : p0_gpio_oe_i[gi+4];
		end
	endgenerate
	logic [3:0] dma_p0;
	assign dma_p0 = {dma_done_3_i, dma_ack_3_i, dma_done_2_i, dma_ack_2_a_i};
	assign p0_pin_o[7:4] = (p1h_dma & dma_p0) | (~p1h_dma & p1h_ser & ser1_out_i)
		| (~p1h_dma & ~p1h_ser & p0_gpio_out_i[7:4]);
	assign p0_port_sel_o = ~{p1h_dma | p1h_ser, p0_fifo | p0_ser};

	// P15 (index 0) and P16 (index 1)
	assign p1_alt = p1_function_select_r[6:5];
	assign p1_s3 = ~p1_alt & {serial3_pin_select_r[1], serial3_pin_select_r[2]};
	assign timer_event_in_o = p1_alt & ~p1_io_control_r[6:5] & p1_pin_i;
	assign ser3_clk_in_o = p1_s3[0] ? p1_pin_i[0] : 1'b1;
	assign p1_pin_o[0] = (p1_alt[0] && p1_io_control_r[5]) ? dma_done_0_i
		: p1_s3[0] ? ser3_clk_out_i : p1_gpio_out_i[0];
	assign p1_pin_oe_o[0] = p1_alt[0] ? p1_io_control_r[5]
		: p1_s3[0] ? ser3_clk_oe_i : p1_gpio_oe_i[0];
	assign p1_pin_o[1] = (p1_alt[1] && p1_io_control_r[6]) ? dma_done_1_i
		: p1_s3[1] ? ser3_tx_i : p1_gpio_out_i[1];
	assign p1_pin_oe_o[1] = p1_alt[1] ? p1_io_control_r[6]
		: p1_s3[1] ? 1'b1 : p1_gpio_oe_i[1];

	// P20..P27
	assign p20_sd = p2_ext_select_fields_r[1:0] == `PPFS_FLD_ALT;
	assign p20_dr = (p2_ext_select_fields_r[1:0] == `PPFS_FLD_GPIO) && p2_function_select_r[0];
	assign p21_sd = p2_ext_select_fields_r[3:2] == `PPFS_FLD_ALT;
	assign p21_ga = (p2_ext_select_fields_r[3:2] == `PPFS_FLD_GPIO)
		&& port_extended_function_r[2];
	assign p21_dw = (p2_ext_select_fields_r[3:2] == `PPFS_FLD_GPIO)
		&& !port_extended_function_r[2] && p2_function_select_r[1];
	assign p2_pin_o[0] = p20_sd ? sdram_clk_en_out_i : p20_dr ? dram_succ_read_i
		: p2_gpio_out_i[0];
	assign p2_pin_oe_o[0] = (p20_sd || p20_dr) ? 1'b1 : p2_gpio_oe_i[0];
	assign p2_pin_o[1] = p21_sd ? sdram_write_strobe_i : p21_ga ? area_addr_strobe_i
		: p21_dw ? dram_succ_write_i : p2_gpio_out_i[1];
	assign p2_pin_oe_o[1] = (p21_sd || p21_ga || p21_dw) ? 1'b1 : p2_gpio_oe_i[1];
	assign p2_tm = p2_function_select_r[7:2];
	// Select bits run opposite to pin order: bit 3 goes to P24, bit 0 to P27
	assign p2_s2 = ~p2_tm[5:2] & {serial2_pin_select_r[0], serial2_pin_select_r[1],
		serial2_pin_select_r[2], serial2_pin_select_r[3]};
	generate
		for (gi = 0; gi < 6; gi++) begin : g_p2
			if (gi < 2) begin : g_tm
				assign p2_pin_o[gi+2] = p2_tm[gi] ? timer16_out_i[gi] : p2_gpio_out_i[gi+2];
				assign p2_pin_oe_o[gi+2] = p2_tm[gi] ? 1'b1 : p2_gpio_oe_i[gi+2];
			end else begin : g_ts
				assign p2_pin_o[gi+2] = p2_tm[gi] ? timer16_out_i[gi]
					: p2_s2[gi-2] ? ser2_out_i[5-gi] : p2_gpio_out_i[gi+2];
				assign p2_pin_oe_o[gi+2] = p2_tm[gi] ? 1'b1
					: p2_s2[gi-2] ? ser2_oe_i[5-gi] : p2_gpio_oe_i[gi+2];
				assign ser2_in_o[5-gi] = p2_s2[gi-2] ? p2_pin_i[gi+2] : 1'b1;
			end
		end
	endgenerate

	// P30, P31
	// Field 01 and the unused codes all leave P30 with the port
	assign p30_alt = (pa_select_fields_r[5:4] == `PPFS_FLD_GPIO)
		&& p3_function_select_r[0];
	assign wait_req_o = (p30_alt && !p3_io_control_r[0]) ? p3_pin_i[0] : 1'b1;
	assign p3_pin_o[0] = (p30_alt && p3_io_control_r[0]) ? area45_select_i : p3_gpio_out_i[0];
	assign p3_pin_oe_o[0] = p30_alt ? p3_io_control_r[0] : p3_gpio_oe_i[0];
	assign p31_mon = p3_function_select_r[1] && !port_extended_function_r[3]
		&& (p3_ext_select_fields_r[3:2] == `PPFS_FLD_GPIO);
	assign p3_pin_o[1] = p31_mon ? bus_release_monitor_i : p3_gpio_out_i[1];
	assign p3_pin_oe_o[1] = p31_mon ? 1'b1 : p3_gpio_oe_i[1];

	assign route_o = '{k5_alt: k5_function_select_r[4:0], k6_alt: k6_function_select_r[4:0],
		p0_port: p0_port_sel_o, p1_port: {1'b1, ~(p1_alt | p1_s3), 5'h1F},
		p2_port: ~({p2_tm, p21_sd | p21_ga | p21_dw, p20_sd | p20_dr} | {p2_s2, 4'h0}),
		p3_port: ~{p31_mon, p30_alt}};

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	k50_route_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		k5_function_select_r[0] |-> dma_request_o[0] == k5_pin_i[0] && !k5_port_o[0])
		else $error("K50 not routed to DMA request");
	k52_route_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!k5_function_select_r[2] |-> adc_trigger_in_o && k5_port_o[2] == k5_pin_i[2])
		else $error("K52 routing wrong");
	fifo_pri_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		p0_ext_select_fields_r[1:0] == `PPFS_FLD_ALT |-> p0_pin_oe_o[0] == fser0_oe_i[0])
		else $error("P00 FIFO select lost");
	dma_ovr_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		port_extended_function_r[4] |-> p0_pin_o[4] == dma_ack_2_a_i && p0_pin_oe_o[4])
		else $error("P04 DMA override lost");
	p16_dma_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		p1_function_select_r[6] && p1_io_control_r[6] |-> p1_pin_o[1] == dma_done_1_i)
		else $error("P16 DMA end not driven");
	timer_out_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		p2_function_select_r[7] |-> p2_pin_o[7] == timer16_out_i[5] && p2_pin_oe_o[7])
		else $error("P27 timer output lost");
	p31_mon_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		port_extended_function_r[3] |-> p3_pin_o[1] == p3_gpio_out_i[1])
		else $error("P31 monitor despite ext bit");
	reset_clear_a: assert property (@(posedge mclk_i)
		sys_rst_i |=> k5_function_select_r == 8'h00 && port_extended_function_r == 8'h00)
		else $error("Select bits not cleared");
	write_eff_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		do_write && wlane_r && wsel == ppfs_pkg::REG_K6 |=> adc_ch_en_o == $past(wbyte_r[4:0]))
		else $error("Routing not updated after write");
	ser2_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		serial2_pin_select_r[0] && !p2_function_select_r[7] |-> ser2_in_o[0] == p2_pin_i[7])
		else $error("Serial 2 input not routed");
	wr_cov_c: cover property (@(posedge mclk_i) do_write ##1 s_axi_bvalid_o);
	rd_cov_c: cover property (@(posedge mclk_i) s_axi_arvalid_i && s_axi_arready_o);
	sd_cov_c: cover property (@(posedge mclk_i) p20_sd && p21_sd);
endmodule : ppfs_top
